// ---- verilog/mcpa_params.svh ----
// Offsets, field positions, reset values and counts of the CPU port
`ifndef MCPA_PARAMS_SVH
`define MCPA_PARAMS_SVH
`define MCPA_REG_CTRL 8'h00
`define MCPA_REG_MASK 8'h01
`define MCPA_REG_STAT 8'h02
`define MCPA_REG_CHIDX 8'h03
`define MCPA_REG_DIR 8'h04
`define MCPA_CTRL_RATE_LSB 0
`define MCPA_CTRL_TDMEN_BIT 2
`define MCPA_CTRL_RESET 8'h00
`define MCPA_MASK_RESET 8'h00
`define MCPA_CHAN_2M 8'h20
`define MCPA_CHAN_4M 8'h40
`define MCPA_CHAN_8M 8'h80
`define MCPA_STREAMS_ALL 8'hff
`define MCPA_STREAMS_HALF 8'h0f
`define MCPA_BITS_PER_CHAN 3'h7
`define MCPA_BIT_DIV 4'h9
`endif

// ---- verilog/mcpa_pkg.sv ----
// Types shared by the CPU port files
`default_nettype none
package mcpa_pkg;
  typedef enum logic [1:0] {
    MCPA_RATE_2M = 2'b00,
    MCPA_RATE_4M = 2'b01,
    MCPA_RATE_8M = 2'b10
  } mcpa_rate_t;
  typedef enum logic [1:0] {
    MCPA_ACK_IDLE = 2'b00,
    MCPA_ACK_WAIT = 2'b01,
    MCPA_ACK_LOW  = 2'b10,
    MCPA_ACK_HIGH = 2'b11
  } mcpa_ack_t;
endpackage
`default_nettype wire

// ---- verilog/mcpa_sync.sv ----
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mcpa_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1;  // Metastable stage, read only by stage two

  // Two flops before any logic looks at a pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= pinIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/mcpa_port.sv ----
// Multiplexed CPU port with alarm interrupt and TDM output enables
//
// Overview of operation
// - Data-strobe style: access only while strobe high, selected
// - Read-strobe style: low read drives bus outward
// - Address latched on address strobe falling edge
// - Chip select high makes device ignore cycles
// - Ack low on completion, high briefly, then float
// - Accesses finish on port clock ticks only
// - Alarm raises interrupt; status register shows source
// - Reset input high clears device; low runs
// - TDM outputs float after reset until programmed
// - Stream carries 32, 64 or 128 channels
// - Top rate uses only first four streams
// - Per-channel stream direction, input by default
`timescale 1ns/1ps
`default_nettype none
`include "mcpa_params.svh"
module mcpa_port #(
  parameter int CHANS = 128,  // Direction memory depth
  parameter int ALARMS = 4    // Alarm sources
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              device_clear_in,
  // Bus style: 1 data-strobe style, 0 read/write-strobe style
  input  wire logic              busStyleDs,
  // Host bus strobes
  input  wire logic              data_strobe_high,
  input  wire logic              rdWrSel,
  input  wire logic              addr_latch_strobe,
  input  wire logic              chipSel_n,
  // Multiplexed address/data bus
  input  wire logic [7:0]        muxed_bus_in,
  output logic      [7:0]        muxed_bus_out,
  output logic                   muxed_bus_oe,
  // Transfer acknowledge, open pin
  output logic                   transfer_ack_n,
  output logic                   transfer_ack_oe,
  // Port clock halt and alarm sources
  input  wire logic              portClkHalt,
  input  wire logic [ALARMS-1:0] alarmIn,
  output logic                   irq,
  // TDM enables and channel position
  output logic      [7:0]        serial_lines_oe,
  output logic      [7:0]        serial_out_lines_oe,
  output logic                   parallel_out_bus_oe,
  output logic      [7:0]        chanNum
);
  import mcpa_pkg::*;

  localparam int SW = 7 + ALARMS;
  logic [SW-1:0] pins;       // Raw pin group
  logic [SW-1:0] syncPins;   // Synchronised pin group
  // Select enters inverted: sync flops clear to 0, which must mean idle
  assign pins = {alarmIn, device_clear_in, data_strobe_high, rdWrSel,
                 addr_latch_strobe, ~chipSel_n, portClkHalt, busStyleDs};

  // All pins enter through two flops
  mcpa_sync #(.W(SW)) uSyncCtl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (pins),
    .syncOut (syncPins)
  );
  logic [7:0] busIn;  // Synchronised bus
  mcpa_sync #(.W(8)) uSyncBus (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (muxed_bus_in),
    .syncOut (busIn)
  );

  wire styleDs = syncPins[0];
  wire clkHalt = syncPins[1];
  wire csN     = ~syncPins[2];  // Reads deselected right after reset
  wire asLvl   = syncPins[3];
  wire rwLvl   = syncPins[4];
  wire dsLvl   = syncPins[5];
  wire clrLvl  = syncPins[6];
  wire [ALARMS-1:0] alarmLvl = syncPins[SW-1:7];

  // Pin clear folds into the reset; held high means held cleared
  wire rst = sys_rst | clrLvl;

  logic asPrev;          // Address strobe last cycle
  logic [7:0] addr;      // Address latch
  logic [7:0] ctrl;      // Rate and output enable
  logic [7:0] mask;      // Alarm mask
  logic [ALARMS-1:0] stat;  // Sticky alarm status
  logic [ALARMS-1:0] alarmPrev;  // Edge detect on alarms
  logic [7:0] chIdx;     // Direction memory index
  logic [7:0] dirMem [CHANS];  // Direction bit per stream per channel
  mcpa_ack_t ackSt;      // Acknowledge sequencer
  mcpa_ack_t next_ackSt;
  logic [3:0] div;       // Bit-rate divider
  logic [2:0] bitCnt;    // Bit within channel
  logic portTick;        // Port clock edge enable

  // Access qualification per bus style
  wire asFall = asPrev & ~asLvl;
  wire dsRead = dsLvl & rwLvl;
  wire dsWrite = dsLvl & ~rwLvl;
  wire rdRead = ~dsLvl;
  wire rdWrite = ~rwLvl & dsLvl;
  wire isRead = styleDs ? dsRead : rdRead;
  wire isWrite = styleDs ? dsWrite : rdWrite;
  wire active = ~csN & (isRead | isWrite);
  wire readActive = ~csN & isRead;

  // Rate decode
  wire [1:0] rateBits = ctrl[`MCPA_CTRL_RATE_LSB +: 2];
  wire tdmEn = ctrl[`MCPA_CTRL_TDMEN_BIT];
  function automatic logic [7:0] chanCount(input logic [1:0] r);
    case (r)
      MCPA_RATE_4M: chanCount = `MCPA_CHAN_4M;
      MCPA_RATE_8M: chanCount = `MCPA_CHAN_8M;
      default:      chanCount = `MCPA_CHAN_2M;
    endcase
  endfunction
  wire [7:0] maxChan = chanCount(rateBits);
  wire [7:0] streamMask = (rateBits == MCPA_RATE_8M) ?
    `MCPA_STREAMS_HALF : `MCPA_STREAMS_ALL;

  // Read data select from latched address
  wire [7:0] dirWord = dirMem[chIdx[6:0]];
  wire [7:0] statWord = {{(8-ALARMS){1'b0}}, stat};
  wire [7:0] readData =
    (addr == `MCPA_REG_CTRL)  ? ctrl :
    (addr == `MCPA_REG_MASK)  ? mask :
    (addr == `MCPA_REG_STAT)  ? statWord :
    (addr == `MCPA_REG_CHIDX) ? chIdx :
    (addr == `MCPA_REG_DIR)   ? dirWord : 8'h00;
  // Store only while still selected; a dropped select cancels it
  wire doWrite = (ackSt == MCPA_ACK_WAIT) & portTick & active & isWrite;
  wire [ALARMS-1:0] alarmSet = alarmLvl & ~alarmPrev;
  wire [ALARMS-1:0] statClr =
    (doWrite && addr == `MCPA_REG_STAT) ? busIn[ALARMS-1:0] : '0;

  // Acknowledge sequencer; moves to low only on a port tick
  always_comb begin
    case (ackSt)
      MCPA_ACK_IDLE: next_ackSt = active ? MCPA_ACK_WAIT : MCPA_ACK_IDLE;
      MCPA_ACK_WAIT: begin
        if (!active) begin
          next_ackSt = MCPA_ACK_IDLE;
        end else if (portTick) begin
          next_ackSt = MCPA_ACK_LOW;
        end else begin
          next_ackSt = MCPA_ACK_WAIT;
        end
      end
      MCPA_ACK_LOW:  next_ackSt = active ? MCPA_ACK_LOW : MCPA_ACK_HIGH;
      MCPA_ACK_HIGH: next_ackSt = MCPA_ACK_IDLE;
      default:       next_ackSt = MCPA_ACK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ackSt <= MCPA_ACK_IDLE;
    end else begin
      ackSt <= next_ackSt;
    end
  end

  // Ack pin: low, then driven high one cycle, then floated
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_ack_n  <= 1'b1;
      transfer_ack_oe <= 1'b0;
    end else begin
      transfer_ack_n  <= (next_ackSt != MCPA_ACK_LOW);
      transfer_ack_oe <= (next_ackSt == MCPA_ACK_LOW) ||
                         (next_ackSt == MCPA_ACK_HIGH);
    end
  end

  // Address latch; holds between address phases
  always_ff @(posedge clk) begin
    if (rst) begin
      asPrev <= 1'b0;
      addr   <= 8'h00;
    end else begin
      asPrev <= asLvl;
      if (asFall) begin
        addr <= busIn;
      end
    end
  end

  // Bus drive during selected reads only
  always_ff @(posedge clk) begin
    if (rst) begin
      muxed_bus_oe  <= 1'b0;
      muxed_bus_out <= 8'h00;
    end else begin
      muxed_bus_oe  <= readActive;
      muxed_bus_out <= readData;
    end
  end

  // Writable registers; stores land on a port tick
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl  <= `MCPA_CTRL_RESET;
      mask  <= `MCPA_MASK_RESET;
      chIdx <= 8'h00;
    end else if (doWrite) begin
      if (addr == `MCPA_REG_CTRL)  ctrl  <= busIn;
      if (addr == `MCPA_REG_MASK)  mask  <= busIn;
      if (addr == `MCPA_REG_CHIDX) chIdx <= busIn;
    end
  end

  // Direction memory; cleared to all inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < CHANS; i++) dirMem[i] <= 8'h00;
    end else if (doWrite && addr == `MCPA_REG_DIR) begin
      dirMem[chIdx[6:0]] <= busIn;
    end
  end

  // Sticky alarms: a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat      <= '0;
      alarmPrev <= '0;
      irq       <= 1'b0;
    end else begin
      alarmPrev <= alarmLvl;
      stat      <= (stat & ~statClr) | alarmSet;
      irq       <= |(stat & mask[ALARMS-1:0]);
    end
  end

  // Port clock divider; a halted clock freezes ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      div      <= 4'h0;
      portTick <= 1'b0;
    end else begin
      portTick <= 1'b0;
      if (!clkHalt) begin
        div <= (div == `MCPA_BIT_DIV) ? 4'h0 : div + 4'h1;
        portTick <= (div == `MCPA_BIT_DIV);
      end
    end
  end

  // Channel position within the frame
  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt  <= 3'h0;
      chanNum <= 8'h00;
    end else if (portTick) begin
      bitCnt <= bitCnt + 3'h1;
      if (bitCnt == `MCPA_BITS_PER_CHAN) begin
        chanNum <= (chanNum >= maxChan - 8'h01) ? 8'h00
                   : chanNum + 8'h01;
      end
    end
  end

  // Output enables, all gated by enable; only serial lines follow direction of current channel
  wire [7:0] curDir = dirMem[chanNum[6:0]];
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_lines_oe     <= 8'h00;
      serial_out_lines_oe <= 8'h00;
      parallel_out_bus_oe <= 1'b0;
    end else begin
      serial_lines_oe     <= tdmEn ? (curDir & streamMask) : 8'h00;
      serial_out_lines_oe <= tdmEn ? streamMask : 8'h00;
      parallel_out_bus_oe <= tdmEn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_drive: assert property (readActive |=> muxed_bus_oe)
    else $error("bus not driven during read");
  a_cs_ignore: assert property (csN |=> !muxed_bus_oe)
    else $error("bus driven while deselected");
  a_addr_latch: assert property (asFall |=> addr == $past(busIn))
    else $error("address not latched on strobe fall");
  a_addr_hold: assert property (!asFall |=> $stable(addr))
    else $error("address moved between phases");
  a_ack_tick: assert property ($fell(transfer_ack_n)
    |-> $past(portTick))
    else $error("ack fell without port tick");
  a_ack_float: assert property ($rose(transfer_ack_n) |-> transfer_ack_oe
    ##1 !transfer_ack_oe)
    else $error("ack not driven high then floated");
  a_alarm_irq: assert property ((alarmSet & mask[ALARMS-1:0]) != '0
    |-> ##2 irq)
    else $error("alarm did not raise interrupt");
  a_tdm_float: assert property (!tdmEn |=> serial_lines_oe == 8'h00
    && !parallel_out_bus_oe)
    else $error("tdm output driven while disabled");
  a_stream_cap: assert property (rateBits == MCPA_RATE_8M
    |=> serial_out_lines_oe[7:4] == 4'h0)
    else $error("upper streams used at top rate");
  a_chan_range: assert property (chanNum < `MCPA_CHAN_8M)
    else $error("channel number out of range");

  c_read: cover property (readActive ##1 !transfer_ack_n);
  c_write: cover property (doWrite);
  c_irq: cover property ($rose(irq));
  c_top_rate: cover property (rateBits == MCPA_RATE_8M && tdmEn);
endmodule
`default_nettype wire

// ---- test/mcpa_host.sv ----
// Host processor model for the multiplexed CPU port
`timescale 1ns/1ps
`default_nettype none
module mcpa_host (
  // Clock
  input  wire logic       clk,
  // Strobes and bus driven by the host, idle at time zero
  output logic            busStyleDs = 1'b1,
  output logic            data_strobe_high = 1'b0,
  output logic            rdWrSel = 1'b1,
  output logic            addr_latch_strobe = 1'b0,
  output logic            chipSel_n = 1'b1,
  output logic      [7:0] hostBus = 8'h00,
  // Device answer
  input  wire logic       transfer_ack_n,
  input  wire logic       transfer_ack_oe,
  input  wire logic [7:0] muxed_bus_out
);
  // One byte access; ok means acked, then ack driven high and floated
  task automatic access(input logic st, rd, csOn, input logic [7:0] a,
                        d, output logic [7:0] q, output logic ok);
    logic hi;
    logic tail;
    ok = 1'b0;
    hi = 1'b0;
    tail = 1'b0;
    q = 8'h00;
    @(posedge clk);
    // Style and idle levels first; pins pass two sync flops
    busStyleDs <= st;
    data_strobe_high <= !st;
    rdWrSel <= 1'b1;
    addr_latch_strobe <= 1'b1;
    hostBus <= a;
    repeat (3) @(posedge clk);
    addr_latch_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    // Data phase; on reads the host drives the inverted address, which the device overrides
    hostBus <= rd ? ~a : d;
    chipSel_n <= !csOn;
    data_strobe_high <= st | !rd;
    rdWrSel <= rd;
    // Bounded wait; sampled mid-cycle where outputs have settled
    for (int n = 0; n < 40 && !ok; n++) begin
      @(negedge clk);
      if (transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b0) begin
        ok = 1'b1;
        q = muxed_bus_out;
      end
    end
    @(posedge clk);
    // Cycle end: strobes idle, bus released to the inverse value
    chipSel_n <= 1'b1;
    data_strobe_high <= !st;
    rdWrSel <= 1'b1;
    hostBus <= ~hostBus;
    // Ack must stand high for a cycle, then float
    repeat (8) begin
      @(negedge clk);
      if (hi && transfer_ack_oe === 1'b0) tail = 1'b1;
      hi = transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b1;
    end
    ok = ok & tail;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the multiplexed CPU port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Row: style, read, address, data written or expected
  typedef struct packed {
    logic       st;
    logic       rd;
    logic [7:0] a;
    logic [7:0] d;
  } mcpa_row_t;
  // Ordinary accesses, both bus styles mixed
  localparam mcpa_row_t ROWS [12] = '{
    '{1'b1, 1'b1, 8'h00, 8'h00}, '{1'b0, 1'b1, 8'h01, 8'h00},
    '{1'b1, 1'b0, 8'h00, 8'h06}, '{1'b0, 1'b1, 8'h00, 8'h06},
    '{1'b0, 1'b0, 8'h03, 8'h05}, '{1'b1, 1'b0, 8'h04, 8'ha5},
    '{1'b1, 1'b1, 8'h04, 8'ha5}, '{1'b1, 1'b0, 8'h03, 8'h06},
    '{1'b0, 1'b1, 8'h04, 8'h00}, '{1'b0, 1'b0, 8'h07, 8'h5a},
    '{1'b1, 1'b1, 8'h07, 8'h00}, '{1'b0, 1'b1, 8'h02, 8'h00}};
  // Bench-driven inputs
  logic       clk = 1'b0;
  logic       sysRst = 1'b1;
  logic       devClr = 1'b0;
  logic       portClkHalt = 1'b0;
  logic [3:0] alarmIn = 4'h0;
  // Host pins
  wire  logic       busStyleDs, dsHigh, rdWrSel, addrStb, chipSel_n;
  wire  logic [7:0] hostBus;
  // Design answers
  logic       busOe, ackN, ackOe, irq, parOe;
  logic [7:0] busOut, chanNum, serOe, serOutOe;
  // Bus level: device wins while it drives
  wire  logic [7:0] busWire = busOe ? busOut : hostBus;
  // Bookkeeping
  int         miscompares = 0;
  int         testsRun = 0;
  logic [7:0] q, mx, orOe;
  logic [7:0] dirOr;  // Direction enables seen over a frame
  logic       ok;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  mcpa_host i_mcpa_host (
    .clk(clk), .busStyleDs(busStyleDs), .data_strobe_high(dsHigh),
    .rdWrSel(rdWrSel), .addr_latch_strobe(addrStb),
    .chipSel_n(chipSel_n), .hostBus(hostBus), .transfer_ack_n(ackN),
    .transfer_ack_oe(ackOe), .muxed_bus_out(busWire));

  mcpa_port i_mcpa_port (
    .clk(clk), .sys_rst(sysRst), .device_clear_in(devClr),
    .busStyleDs(busStyleDs), .data_strobe_high(dsHigh),
    .rdWrSel(rdWrSel), .addr_latch_strobe(addrStb),
    .chipSel_n(chipSel_n), .muxed_bus_in(busWire),
    .muxed_bus_out(busOut), .muxed_bus_oe(busOe),
    .transfer_ack_n(ackN), .transfer_ack_oe(ackOe),
    .portClkHalt(portClkHalt), .alarmIn(alarmIn), .irq(irq),
    .serial_lines_oe(serOe), .serial_out_lines_oe(serOutOe),
    .parallel_out_bus_oe(parOe), .chanNum(chanNum));

  // Compare and count
  task automatic check(input logic [7:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Access through the host, completion compared with expectation
  task automatic acc(input logic st, rd, cs, input logic [7:0] a, d,
                     input logic expOk);
    i_mcpa_host.access(st, rd, cs, a, d, q, ok);
    check({7'h00, ok}, {7'h00, expOk});
  endtask

  task automatic done(input string s);
    $display("Test %s finished, %0d checks so far", s, testsRun);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    @(negedge clk);
    check(serOe | serOutOe | {7'h00, parOe}, 8'h00);
    foreach (ROWS[i]) begin
      acc(ROWS[i].st, ROWS[i].rd, 1'b1, ROWS[i].a, ROWS[i].d, 1'b1);
      if (ROWS[i].rd) check(q, ROWS[i].d);
    end
    done("table");
    // Deselected write must not land
    acc(1'b1, 1'b0, 1'b0, 8'h00, 8'h03, 1'b0);
    acc(1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1);
    check(q, 8'h06);
    done("chip select");
    // Halted port clock: no ack, no write
    @(posedge clk);
    portClkHalt <= 1'b1;
    acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h01, 1'b0);
    @(posedge clk);
    portClkHalt <= 1'b0;
    acc(1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1);
    check(q, 8'h06);
    done("halt");
    // Alarm masked, then unmasked, then cleared
    @(posedge clk);
    alarmIn <= 4'h2;
    acc(1'b1, 1'b1, 1'b1, 8'h02, 8'h00, 1'b1);
    check(q, 8'h02);
    check({7'h00, irq}, 8'h00);
    acc(1'b0, 1'b0, 1'b1, 8'h01, 8'h02, 1'b1);
    check({7'h00, irq}, 8'h01);
    acc(1'b1, 1'b0, 1'b1, 8'h02, 8'h02, 1'b1);
    check({7'h00, irq}, 8'h00);
    @(posedge clk);
    alarmIn <= 4'h0;
    // New event while unmasked raises the interrupt directly
    repeat (4) @(posedge clk);
    alarmIn <= 4'h2;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({7'h00, irq}, 8'h01);
    @(posedge clk);
    alarmIn <= 4'h0;
    done("alarm");
    // Frame length per rate; top rate keeps streams 7:4 off
    for (int r = 0; r < 3; r++) begin
      acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h04 | 8'(r), 1'b1);
      // Let the old rate's channel count wrap before watching
      repeat (100) @(negedge clk);
      mx = 8'h00;
      orOe = 8'h00;
      dirOr = 8'h00;
      repeat ((32 << r) * 80 + 200) begin
        @(negedge clk);
        if (chanNum > mx) mx = chanNum;
        orOe = orOe | serOe | serOutOe;
        dirOr = dirOr | serOe;
      end
      check(mx, 8'((32 << r) - 1));
      if (r == 2) check(orOe & 8'hf0, 8'h00);
      check(dirOr, (r == 2) ? 8'h05 : 8'ha5);
    end
    done("rates");
    // Device clear pin floats outputs and clears registers
    @(posedge clk);
    devClr <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check(serOe | serOutOe | {7'h00, parOe}, 8'h00);
    @(posedge clk);
    devClr <= 1'b0;
    acc(1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1);
    check(q, 8'h00);
    done("device clear");
    give_verdict;
  end
endmodule
`default_nettype wire
